// ==== common/lpd_pkg.sv ====
// Package with offsets, resets and carrier types of the link parameter bank.
// Contract
// - Samples field bits 4:0 hold samples minus one, reset 0x1, one or two.
// - Density bit 7 reads one for high density, resets one, read-only.
// - Control words field bits 4:0 and bits 6:5 read zero.
// - Lane status bit per lane reads one on deskew achieved, resets zero.
// - Lane status bit 6 reports lane 6 initial synchronization state.
// - Checksum register is eight-bit read/write for lane 0, resets zero.
`default_nettype none
package lpd_pkg;

    localparam int          ADDR_W            = 12;
    localparam int          NUM_LANES         = 8;

    localparam logic [11:0] OFS_SAMPLES_VER   = 12'h459;
    localparam logic [11:0] OFS_DENSITY_CW    = 12'h45A;
    localparam logic [11:0] OFS_SPARE_ONE     = 12'h45B;
    localparam logic [11:0] OFS_SPARE_TWO     = 12'h45C;
    localparam logic [11:0] OFS_CONFIG_SUM    = 12'h45D;
    localparam logic [11:0] OFS_LANE_STATUS   = 12'h46C;

    localparam logic [4:0]  RST_SAMPLES_M1    = 5'h01;
    localparam logic [2:0]  RST_VERSION       = 3'h0;
    localparam logic        RST_HIGH_DENSITY  = 1'h1;
    localparam logic [7:0]  RST_SPARE         = 8'h00;
    localparam logic [7:0]  RST_CONFIG_SUM    = 8'h00;
    localparam logic [7:0]  RST_LANE_STATUS   = 8'h00;

    localparam int          VERSION_LSB       = 5;
    localparam int          DENSITY_BIT       = 7;
    localparam int          LANE6_SYNC_BIT    = 6;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr;
        logic              rd;
        logic [7:0]        wdata;
    } lpd_req_type;

    typedef struct packed {
        logic [2:0] interface_version_field;
        logic [7:0] spare_field_one;
        logic [7:0] spare_field_two;
        logic [7:0] lane_zero_config_sum;
    } lpd_cfg_type;

endpackage : lpd_pkg
`default_nettype wire

// ==== core/lpd_sync2.sv ====
// Two-flop synchroniser, one per bit, for status levels from the lanes.
`timescale 1ns/10ps
`default_nettype none
module lpd_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    stage_one[i] <= 1'b0;
                    sync_out[i]  <= 1'b0;
                end else begin
                    stage_one[i] <= async_in[i];
                    sync_out[i]  <= stage_one[i];
                end
            end
        end
    endgenerate

endmodule : lpd_sync2
`default_nettype wire

// ==== core/lpd_regs.sv ====
// Link parameter and lane deskew status register bank.
`timescale 1ns/10ps
`default_nettype none
module lpd_regs #(
    parameter logic [4:0] SAMPLES_MINUS1 = lpd_pkg::RST_SAMPLES_M1,
    parameter int         NUM_LANES      = lpd_pkg::NUM_LANES
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire lpd_pkg::lpd_req_type req,
    output var  logic [7:0]           rdata,
    output var  logic                 rvalid,
    input  wire logic [NUM_LANES-1:0] lane_status_in,
    input  wire logic                 skip_alignment_sequence,
    output var  logic                 lane_status_valid,
    output var  lpd_pkg::lpd_cfg_type cfg
);

    // Lane status levels come from the lane logic in another timing region.
    logic [NUM_LANES-1:0] lane_status;

    lpd_sync2 #(
        .WIDTH    (NUM_LANES)
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (lane_status_in),
        .sync_out (lane_status)
    );

    // Address decode.
    wire logic hit_samples;
    wire logic hit_density;
    wire logic hit_spare_one;
    wire logic hit_spare_two;
    wire logic hit_sum;
    wire logic hit_status;

    assign hit_samples   = (req.addr == lpd_pkg::OFS_SAMPLES_VER);
    assign hit_density   = (req.addr == lpd_pkg::OFS_DENSITY_CW);
    assign hit_spare_one = (req.addr == lpd_pkg::OFS_SPARE_ONE);
    assign hit_spare_two = (req.addr == lpd_pkg::OFS_SPARE_TWO);
    assign hit_sum       = (req.addr == lpd_pkg::OFS_CONFIG_SUM);
    assign hit_status    = (req.addr == lpd_pkg::OFS_LANE_STATUS);

    // Read-only images of the fixed fields.
    wire logic [7:0] samples_img;
    wire logic [7:0] density_img;
    wire logic [7:0] status_img;

    // The version bits are stored; the samples bits are fixed.
    assign samples_img = {cfg.interface_version_field, SAMPLES_MINUS1};
    // High density reported, control words and reserved bits zero.
    assign density_img = {lpd_pkg::RST_HIGH_DENSITY, 7'h00};
    // Bit n is lane n deskew; bit 6 carries lane 6 synchronisation.
    assign status_img  = 8'(lane_status);

    wire logic [7:0] next_rdata;

    assign next_rdata = hit_samples   ? samples_img :
                        hit_density   ? density_img :
                        hit_spare_one ? cfg.spare_field_one :
                        hit_spare_two ? cfg.spare_field_two :
                        hit_sum       ? cfg.lane_zero_config_sum :
                        hit_status    ? status_img :
                        8'h00;

    // Status bits carry meaning only while the alignment sequence runs.
    assign lane_status_valid = ~skip_alignment_sequence;

    // Writable fields. Only stored bits take write data.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg.interface_version_field <= lpd_pkg::RST_VERSION;
            cfg.spare_field_one         <= lpd_pkg::RST_SPARE;
            cfg.spare_field_two         <= lpd_pkg::RST_SPARE;
            cfg.lane_zero_config_sum    <= lpd_pkg::RST_CONFIG_SUM;
        end else if (req.wr) begin
            if (hit_samples) begin
                cfg.interface_version_field <=
                    req.wdata[7:lpd_pkg::VERSION_LSB];
            end
            if (hit_spare_one) begin
                cfg.spare_field_one <= req.wdata;
            end
            if (hit_spare_two) begin
                cfg.spare_field_two <= req.wdata;
            end
            if (hit_sum) begin
                cfg.lane_zero_config_sum <= req.wdata;
            end
        end
    end

    // Read data is registered; answer one cycle after the read strobe.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    property p_samples_field;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_samples) |=> (rdata[4:0] == SAMPLES_MINUS1);
    endproperty
    a_samples_field: assert property (p_samples_field)
        else $error("samples field read wrong");

    property p_samples_range;
        @(posedge mclk) disable iff (rst)
        SAMPLES_MINUS1 <= 5'h01;
    endproperty
    a_samples_range: assert property (p_samples_range)
        else $error("samples setting not one or two");

    property p_density_read;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_density) |=> (rdata == 8'h80);
    endproperty
    a_density_read: assert property (p_density_read)
        else $error("density register read wrong");

    property p_status_read;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_status) |=>
            (rdata[NUM_LANES-1:0] == $past(lane_status) && rvalid);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("lane status read wrong");

    property p_lane6_sync;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_status && lane_status[lpd_pkg::LANE6_SYNC_BIT])
            |=> rdata[lpd_pkg::LANE6_SYNC_BIT];
    endproperty
    a_lane6_sync: assert property (p_lane6_sync)
        else $error("lane 6 sync bit lost");

    property p_sum_write;
        @(posedge mclk) disable iff (rst)
        (req.wr && hit_sum) |=>
            (cfg.lane_zero_config_sum == $past(req.wdata));
    endproperty
    a_sum_write: assert property (p_sum_write)
        else $error("checksum write not stored");

    property p_sum_hold;
        @(posedge mclk) disable iff (rst)
        !(req.wr && hit_sum) |=> $stable(cfg.lane_zero_config_sum);
    endproperty
    a_sum_hold: assert property (p_sum_hold)
        else $error("checksum changed without write");

    property p_ro_ignored;
        @(posedge mclk) disable iff (rst)
        (req.wr && (hit_density || hit_status)) |=> $stable(cfg);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored)
        else $error("read-only write changed state");

    property p_spare_write;
        @(posedge mclk) disable iff (rst)
        (req.wr && hit_spare_two) |=>
            (cfg.spare_field_two == $past(req.wdata));
    endproperty
    a_spare_write: assert property (p_spare_write)
        else $error("spare field two not stored");

    property p_spare_one_write;
        @(posedge mclk) disable iff (rst)
        (req.wr && hit_spare_one) |=>
            (cfg.spare_field_one == $past(req.wdata));
    endproperty
    a_spare_one_write: assert property (p_spare_one_write)
        else $error("spare field one not stored");

    property p_spare_hold;
        @(posedge mclk) disable iff (rst)
        !(req.wr && (hit_spare_one || hit_spare_two)) |=>
            ($stable(cfg.spare_field_one) && $stable(cfg.spare_field_two));
    endproperty
    a_spare_hold: assert property (p_spare_hold)
        else $error("spare field changed without write");

    property p_version_write;
        @(posedge mclk) disable iff (rst)
        (req.wr && hit_samples) |=>
            (cfg.interface_version_field == $past(req.wdata[7:5]));
    endproperty
    a_version_write: assert property (p_version_write)
        else $error("interface version not stored");

    property p_version_hold;
        @(posedge mclk) disable iff (rst)
        !(req.wr && hit_samples) |=> $stable(cfg.interface_version_field);
    endproperty
    a_version_hold: assert property (p_version_hold)
        else $error("interface version changed without write");

    property p_cw_zero;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_density) |=> (rdata[6:0] == 7'h00);
    endproperty
    a_cw_zero: assert property (p_cw_zero)
        else $error("control words or reserved bits not zero");

    property p_density_bit;
        @(posedge mclk) disable iff (rst)
        (req.rd && hit_density) |=> rdata[lpd_pkg::DENSITY_BIT];
    endproperty
    a_density_bit: assert property (p_density_bit)
        else $error("high density bit clear");

    property p_read_answer;
        @(posedge mclk) disable iff (rst)
        req.rd |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in one cycle");

    property p_read_quiet;
        @(posedge mclk) disable iff (rst)
        !req.rd |=> !rvalid;
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("read answer without read strobe");

endmodule : lpd_regs
`default_nettype wire

// ==== testbench/lpd_lane_model.sv ====
// Lane-side model that drives deskew and sync status levels.
`timescale 1ns/10ps
`default_nettype none
module lpd_lane_model (
    input  wire logic [7:0] target,
    output var  logic [7:0] lane_status
);
    // Levels move off the clock grid, as from an unrelated lane clock.
    initial begin
        lane_status = 8'h00;
        forever begin
            @(target);
            lane_status <= #7.3 target;
        end
    end
endmodule : lpd_lane_model
`default_nettype wire

// ==== testbench/tb_link_params_deskew_status.sv ====
// Self-checking bench for the link parameter and lane status bank.
`timescale 1ns/10ps
`default_nettype none
module tb_link_params_deskew_status;
    logic                 mclk        = 1'b0;
    logic                 rst         = 1'b1;
    lpd_pkg::lpd_req_type req         = '0;
    logic [7:0]           target      = 8'h00;
    logic                 skip        = 1'b0;
    logic [31:0]          seed        = 32'h3992;
    int                   n_fail      = 0;
    int                   check_count = 0;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [7:0]           lane_status;
    logic                 lane_status_valid;
    lpd_pkg::lpd_cfg_type cfg;
    logic [7:0]           s1, s2, sum;
    logic [2:0]           ver;

    always #2 mclk = ~mclk;

    lpd_lane_model u_lpd_lane_model (.target(target),
        .lane_status(lane_status));
    lpd_regs u_lpd_regs (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .lane_status_in(lane_status),
        .skip_alignment_sequence(skip),
        .lane_status_valid(lane_status_valid), .cfg(cfg));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs

    // Field-value sum over version, sample count and both spare fields.
    function automatic logic [7:0] fsum(input logic [2:0] v,
                                        input logic [7:0] a, b);
        return 8'(v + lpd_pkg::RST_SAMPLES_M1 + 1 + a + b);
    endfunction : fsum

    task automatic nxt(output logic [7:0] v);
        seed = xs(seed);
        v = seed[7:0];
    endtask : nxt

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        int i;
        @(posedge mclk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 4) begin
            n_fail++;
            print_verdict;
        end else begin
            chk({24'h0, rdata}, {24'h0, e});
        end
    endtask : rd

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(lpd_pkg::OFS_SAMPLES_VER, 8'h01);
        rd(lpd_pkg::OFS_DENSITY_CW, 8'h80);
        rd(lpd_pkg::OFS_SPARE_ONE, 8'h00);
        rd(lpd_pkg::OFS_SPARE_TWO, 8'h00);
        rd(lpd_pkg::OFS_CONFIG_SUM, 8'h00);
        rd(lpd_pkg::OFS_LANE_STATUS, 8'h00);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            nxt(s1);
            nxt(s2);
            nxt(sum);
            if (k == 0)
                s1 = 8'hFF;
            ver = sum[7:5];
            sum = fsum(ver, s1, s2);
            wr(lpd_pkg::OFS_SAMPLES_VER, {ver, ~sum[4:0]});
            wr(lpd_pkg::OFS_SPARE_ONE, s1);
            wr(lpd_pkg::OFS_SPARE_TWO, s2);
            wr(lpd_pkg::OFS_CONFIG_SUM, sum);
            rd(lpd_pkg::OFS_SAMPLES_VER, {ver, 5'h01});
            rd(lpd_pkg::OFS_SPARE_ONE, s1);
            rd(lpd_pkg::OFS_SPARE_TWO, s2);
            rd(lpd_pkg::OFS_CONFIG_SUM, sum);
            chk({5'h0, cfg}, {5'h0, ver, s1, s2, sum});
        end
        $display("test config fields done");
        wr(lpd_pkg::OFS_DENSITY_CW, 8'h00);
        wr(lpd_pkg::OFS_LANE_STATUS, 8'hFF);
        wr(12'h460, 8'h5A);
        rd(lpd_pkg::OFS_DENSITY_CW, 8'h80);
        rd(lpd_pkg::OFS_LANE_STATUS, 8'h00);
        rd(12'h460, 8'h00);
        chk({5'h0, cfg}, {5'h0, ver, s1, s2, sum});
        $display("test read-only done");
        for (int k = 0; k < 6; k++) begin
            nxt(s1);
            nxt(s2);
            if (k == 0)
                s1 = 8'h40;
            @(posedge mclk);
            target <= s1;
            skip <= s2[0];
            repeat (6) @(posedge mclk);
            rd(lpd_pkg::OFS_LANE_STATUS, s1);
            chk({31'h0, lane_status_valid}, {31'h0, ~skip});
        end
        $display("test lane status done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk({5'h0, cfg}, 32'h0);
        rd(lpd_pkg::OFS_CONFIG_SUM, 8'h00);
        rd(lpd_pkg::OFS_SAMPLES_VER, 8'h01);
        $display("test second reset done");
        print_verdict;
    end
endmodule : tb_link_params_deskew_status
`default_nettype wire
